// file: qsflc_top.sv
// transfer-length control of a quad serial flash controller
// assumes an AXI4-Lite master on i_clk_sys and a flash data path on
// i_clk_link that pulses i_link_byte_done once per byte moved
//
// Design decisions made here: the address map and register access over AXI4-Lite.
`timescale 1ns/1ps
`include "qsflc_params.svh"
// Functional notes
// - indirect and polling move count plus one
// - all-ones indirect count runs to memory end
// - undefined length at maximum size never ends
// - dual memory forces count bit zero high
// - memory-mapped mode ignores the count
// - count writable only while not busy
module qsflc_top (
    input wire logic i_clk_sys,
    input wire logic i_rstn,
    input wire logic i_clk_link,
    input wire logic i_link_byte_done,
    input wire logic [7:0] i_awaddr,
    input wire logic i_awvalid,
    output logic o_awready,
    input wire logic [31:0] i_wdata,
    input wire logic [3:0] i_wstrb,
    input wire logic i_wvalid,
    output logic o_wready,
    output logic [1:0] o_bresp,
    output logic o_bvalid,
    input wire logic i_bready,
    input wire logic [7:0] i_araddr,
    input wire logic i_arvalid,
    output logic o_arready,
    output logic [31:0] o_rdata,
    output logic [1:0] o_rresp,
    output logic o_rvalid,
    input wire logic i_rready,
    output logic o_busy,
    output logic o_link_active,
    output logic o_link_last
);
    // stored registers
    logic [31:0] len_q;
    logic [31:0] addr_q;
    logic dual_q;
    logic [1:0] func_mode_q;
    logic [4:0] mem_size_q;
    logic stop_q;
    logic start_tgl_q;
    logic [2:0] done_sync_q;
    logic link_done_tgl;
    qsflc_pkg::qsflc_count_t target_q;
    logic infinite_q;
    // bus state
    logic aw_got_q;
    logic w_got_q;
    logic [7:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    // decode wires
    logic aw_hs;
    logic w_hs;
    logic ar_hs;
    logic wr_fire;
    logic wr_ctrl;
    logic wr_addr;
    logic wr_len;
    logic wr_stat;
    logic wr_hit;
    logic rd_hit;
    logic done_seen;
    logic start_req;
    logic [31:0] wmask;
    logic [31:0] len_eff;
    logic [31:0] ctrl_view;
    logic [31:0] rd_mux;
    logic undef_len;
    logic mmap_mode;
    logic [32:0] mem_end;
    qsflc_pkg::qsflc_count_t target_d;
    logic infinite_d;

    // byte-lane mask from the held strobes
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi = gi + 1) begin : g_lane
            assign wmask[gi*8 +: 8] = {8{wstrb_q[gi]}};
        end
    endgenerate

    // write channel decode
    assign aw_hs = i_awvalid && o_awready;
    assign w_hs = i_wvalid && o_wready;
    assign ar_hs = i_arvalid && o_arready;
    assign wr_fire = aw_got_q && w_got_q && !o_bvalid;
    assign wr_ctrl = wr_fire && (awaddr_q == `QSFLC_OFS_CTRL);
    assign wr_stat = wr_fire && (awaddr_q == `QSFLC_OFS_STAT);
    assign wr_addr = wr_fire && (awaddr_q == `QSFLC_OFS_ADDR);
    assign wr_len = wr_fire && (awaddr_q == `QSFLC_OFS_LEN);
    assign wr_hit = wr_ctrl || wr_stat || wr_addr || wr_len;
    assign start_req = wr_ctrl && wstrb_q[0]
        && wdata_q[`QSFLC_CTRL_START] && !o_busy;

    // effective count and transfer sizing
    assign len_eff = {len_q[31:1], len_q[0] | dual_q};
    assign mmap_mode = (func_mode_q == `QSFLC_MODE_MMAP);
    assign undef_len = (len_eff == `QSFLC_LEN_UNDEF)
        && (func_mode_q != `QSFLC_MODE_POLL);
    assign mem_end = (33'h1 << ({1'b0, mem_size_q} + 6'h1))
        - {1'b0, addr_q};
    assign infinite_d = mmap_mode
        || (undef_len && mem_size_q == `QSFLC_SIZE_MAX);
    assign target_d = undef_len ? mem_end
        : {1'b0, len_eff} + 33'h1;

    // read data selection
    assign ctrl_view = {19'h0, mem_size_q, 2'h0, func_mode_q, 1'b0, dual_q,
        stop_q, 1'b0};
    assign rd_hit = (i_araddr == `QSFLC_OFS_CTRL)
        || (i_araddr == `QSFLC_OFS_STAT)
        || (i_araddr == `QSFLC_OFS_ADDR)
        || (i_araddr == `QSFLC_OFS_LEN);
    assign rd_mux = (i_araddr == `QSFLC_OFS_CTRL) ? ctrl_view
        : (i_araddr == `QSFLC_OFS_STAT) ? {31'h0, o_busy}
        : (i_araddr == `QSFLC_OFS_ADDR) ? addr_q
        : (i_araddr == `QSFLC_OFS_LEN) ? len_eff
        : 32'h0;
    assign done_seen = done_sync_q[1] ^ done_sync_q[2];

    // write address and data capture, either order
    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            aw_got_q <= 1'b0;
            w_got_q <= 1'b0;
            awaddr_q <= 8'h0;
            wdata_q <= 32'h0;
            wstrb_q <= 4'h0;
        end else begin
            if (aw_hs) begin
                aw_got_q <= 1'b1;
                awaddr_q <= i_awaddr;
            end else if (wr_fire) begin
                aw_got_q <= 1'b0;
            end
            if (w_hs) begin
                w_got_q <= 1'b1;
                wdata_q <= i_wdata;
                wstrb_q <= i_wstrb;
            end else if (wr_fire) begin
                w_got_q <= 1'b0;
            end
        end
    end

    // ready flags and write response
    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            o_awready <= 1'b0;
            o_wready <= 1'b0;
            o_bvalid <= 1'b0;
            o_bresp <= `QSFLC_RESP_OKAY;
        end else begin
            o_awready <= !aw_hs && !aw_got_q && !o_bvalid;
            o_wready <= !w_hs && !w_got_q && !o_bvalid;
            if (wr_fire) begin
                o_bvalid <= 1'b1;
                o_bresp <= wr_hit ? `QSFLC_RESP_OKAY : `QSFLC_RESP_SLVERR;
            end else if (i_bready) begin
                o_bvalid <= 1'b0;
            end
        end
    end

    // read channel, answered one cycle after the address is taken
    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            o_arready <= 1'b0;
            o_rvalid <= 1'b0;
            o_rdata <= 32'h0;
            o_rresp <= `QSFLC_RESP_OKAY;
        end else begin
            o_arready <= !ar_hs && !o_rvalid;
            if (ar_hs) begin
                o_rvalid <= 1'b1;
                o_rdata <= rd_mux;
                o_rresp <= rd_hit ? `QSFLC_RESP_OKAY : `QSFLC_RESP_SLVERR;
            end else if (i_rready) begin
                o_rvalid <= 1'b0;
            end
        end
    end

    // count, address and mode fields, locked while busy
    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            len_q <= `QSFLC_LEN_RST;
            addr_q <= `QSFLC_ADDR_RST;
            dual_q <= 1'b0;
            func_mode_q <= 2'h0;
            mem_size_q <= 5'h0;
        end else if (!o_busy) begin
            if (wr_len) begin
                len_q <= (len_q & ~wmask) | (wdata_q & wmask);
            end
            if (wr_addr) begin
                addr_q <= (addr_q & ~wmask) | (wdata_q & wmask);
            end
            if (wr_ctrl && wstrb_q[0]) begin
                dual_q <= wdata_q[`QSFLC_CTRL_DUAL];
                func_mode_q <= wdata_q[`QSFLC_CTRL_MODE_HI:`QSFLC_CTRL_MODE_LO];
            end
            if (wr_ctrl && wstrb_q[1]) begin
                mem_size_q <= wdata_q[`QSFLC_CTRL_SIZE_HI:`QSFLC_CTRL_SIZE_LO];
            end
        end
    end

    // busy, start toggle, abort level and transfer snapshot
    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            o_busy <= 1'b0;
            start_tgl_q <= 1'b0;
            stop_q <= 1'b0;
            target_q <= 33'h0;
            infinite_q <= 1'b0;
        end else if (start_req) begin
            o_busy <= 1'b1;
            start_tgl_q <= ~start_tgl_q;
            target_q <= target_d;
            infinite_q <= infinite_d;
        end else if (done_seen) begin
            o_busy <= 1'b0;
            stop_q <= 1'b0;
        end else if (wr_ctrl && wstrb_q[0] && wdata_q[`QSFLC_CTRL_ABORT]
            && o_busy) begin
            stop_q <= 1'b1;
        end
    end

    // completion toggle from the link domain, three stages
    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            done_sync_q <= 3'h0;
        end else begin
            done_sync_q <= {done_sync_q[1:0], link_done_tgl};
        end
    end

    // link-side counter
    qsflc_link_engine u_link (
        .i_clk_link(i_clk_link),
        .i_rstn(i_rstn),
        .i_start_tgl(start_tgl_q),
        .i_stop(stop_q),
        .i_target(target_q),
        .i_infinite(infinite_q),
        .i_byte_done(i_link_byte_done),
        .o_active(o_link_active),
        .o_last(o_link_last),
        .o_done_tgl(link_done_tgl)
    );

    default clocking cb_sys @(posedge i_clk_sys); endclocking
    default disable iff (!i_rstn);

    sequence s_len_write_busy;
        wr_len && o_busy;
    endsequence
    sequence s_len_write_idle;
        wr_len && !o_busy && (&wstrb_q);
    endsequence

    len_lock_a: assert property (
        s_len_write_busy |=> $stable(len_q))
        else $error("count changed while busy");
    len_drop_a: assert property (
        o_busy && !start_req |=> $stable(len_q) && $stable(func_mode_q))
        else $error("locked field changed while busy");
    len_store_a: assert property (
        s_len_write_idle |=> len_q == $past(wdata_q))
        else $error("idle count write not stored");
    dual_bit_a: assert property (
        ar_hs && dual_q && i_araddr == `QSFLC_OFS_LEN |=> o_rdata[0])
        else $error("count bit zero read low in dual mode");
    even_count_a: assert property (
        start_req && dual_q && !undef_len |=> !target_q[0])
        else $error("dual mode run sized to an odd byte count");
    target_plus_a: assert property (
        start_req && !undef_len
        |=> target_q == {1'b0, $past(len_eff)} + 33'h1)
        else $error("target is not count plus one");
    undef_end_a: assert property (
        start_req && undef_len && mem_size_q != `QSFLC_SIZE_MAX && !mmap_mode
        |=> !infinite_q && target_q == $past(mem_end))
        else $error("undefined length not sized to memory end");
    undef_forever_a: assert property (
        start_req && undef_len && mem_size_q == `QSFLC_SIZE_MAX
        |=> infinite_q)
        else $error("undefined length at maximum size not endless");
    mmap_ignore_a: assert property (
        start_req && mmap_mode |=> infinite_q)
        else $error("memory-mapped run sized by count");
    busy_start_a: assert property (
        start_req |=> o_busy ##1 o_busy)
        else $error("busy not held after start");
    bresp_pair_a: assert property (
        wr_fire |=> o_bvalid)
        else $error("write response missing");
endmodule : qsflc_top

// file: qsflc_params.svh
// constants for the serial flash transfer-length block
// assumes inclusion by both design files of the block
`ifndef QSFLC_PARAMS_SVH
`define QSFLC_PARAMS_SVH
// register byte offsets
`define QSFLC_OFS_CTRL 8'h00
`define QSFLC_OFS_STAT 8'h04
`define QSFLC_OFS_ADDR 8'h08
`define QSFLC_OFS_LEN 8'h0c
// control field positions
`define QSFLC_CTRL_START 0
`define QSFLC_CTRL_ABORT 1
`define QSFLC_CTRL_DUAL 2
`define QSFLC_CTRL_MODE_LO 4
`define QSFLC_CTRL_MODE_HI 5
`define QSFLC_CTRL_SIZE_LO 8
`define QSFLC_CTRL_SIZE_HI 12
`define QSFLC_STAT_BUSY 0
// encodings and reset values
`define QSFLC_MODE_MMAP 2'h2
`define QSFLC_MODE_POLL 2'h3
`define QSFLC_SIZE_MAX 5'h1f
`define QSFLC_LEN_UNDEF 32'hffff_ffff
`define QSFLC_LEN_RST 32'h0000_0000
`define QSFLC_ADDR_RST 32'h0000_0000
`define QSFLC_RESP_OKAY 2'h0
`define QSFLC_RESP_SLVERR 2'h2
`endif

// file: qsflc_pkg.sv
// types shared by the serial flash transfer-length block
// assumes nothing of its surroundings
package qsflc_pkg;
    typedef logic [32:0] qsflc_count_t;
    typedef enum logic [1:0] {
        QSFLC_FM_IND_WR,
        QSFLC_FM_IND_RD,
        QSFLC_FM_MMAP,
        QSFLC_FM_POLL
    } qsflc_func_mode_e;
endpackage : qsflc_pkg

// file: qsflc_link_engine.sv
// link-side byte counter of the transfer-length block
// assumes start toggle, stop level and target come from the system clock
// domain; target and infinite stay stable while the system side is busy
`timescale 1ns/1ps
`include "qsflc_params.svh"
module qsflc_link_engine (
    input wire logic i_clk_link,
    input wire logic i_rstn,
    input wire logic i_start_tgl,
    input wire logic i_stop,
    input wire qsflc_pkg::qsflc_count_t i_target,
    input wire logic i_infinite,
    input wire logic i_byte_done,
    output logic o_active,
    output logic o_last,
    output logic o_done_tgl
);
    logic [2:0] start_sync_q;
    logic [2:0] stop_sync_q;
    qsflc_pkg::qsflc_count_t count_q;
    logic [32:0] count_inc;
    logic start_seen;
    logic stop_seen;
    logic hit_end;

    // three-stage synchronisers, decisions only on stages two and three
    always_ff @(posedge i_clk_link or negedge i_rstn) begin
        if (!i_rstn) begin
            start_sync_q <= 3'h0;
            stop_sync_q <= 3'h0;
        end else begin
            start_sync_q <= {start_sync_q[1:0], i_start_tgl};
            stop_sync_q <= {stop_sync_q[1:0], i_stop};
        end
    end

    // decode of start, stop and the final byte
    assign start_seen = start_sync_q[1] ^ start_sync_q[2];
    assign stop_seen = stop_sync_q[1] & stop_sync_q[2];
    assign count_inc = count_q + 33'h1;
    assign hit_end = !i_infinite && (count_inc == i_target);

    // byte counting; infinite runs end only on stop
    always_ff @(posedge i_clk_link or negedge i_rstn) begin
        if (!i_rstn) begin
            count_q <= 33'h0;
            o_active <= 1'b0;
            o_last <= 1'b0;
            o_done_tgl <= 1'b0;
        end else if (start_seen) begin
            count_q <= 33'h0;
            o_active <= 1'b1;
            o_last <= !i_infinite && (i_target == 33'h1);
        end else if (o_active && stop_seen) begin
            o_active <= 1'b0;
            o_last <= 1'b0;
            o_done_tgl <= ~o_done_tgl;
        end else if (o_active && i_byte_done) begin
            count_q <= count_inc;
            o_last <= !i_infinite && (count_inc + 33'h1 == i_target);
            if (hit_end) begin
                o_active <= 1'b0;
                o_last <= 1'b0;
                o_done_tgl <= ~o_done_tgl;
            end
        end
    end

    default clocking cb_link @(posedge i_clk_link); endclocking
    default disable iff (!i_rstn);

    // a finite run ends on the byte that reaches the target
    end_on_target_a: assert property (
        o_active && i_byte_done && !stop_seen && !start_seen && hit_end
        |=> !o_active && $changed(o_done_tgl))
        else $error("finite run did not end at target");
    // an infinite run never ends on a byte
    infinite_runs_on_a: assert property (
        o_active && i_infinite && i_byte_done && !stop_seen && !start_seen
        |=> o_active)
        else $error("infinite run ended by itself");
endmodule : qsflc_link_engine

// file: qsflc_flash_model.sv
// behavioural far-side data path of the transfer-length block
// assumes the link clock and reset of the block; pulses one byte per
// strobe only in the cycle after the block reports a run in progress
`timescale 1ns/1ps
module qsflc_flash_model (
    input wire logic i_clk_link,
    input wire logic i_rstn,
    input wire logic i_active,
    input wire logic i_slow,
    output logic o_byte_done,
    output logic [31:0] o_count
);
    logic [1:0] gap_q;
    // byte strobes, back to back or one in four when slow; count only
    // strobes the block can see, so a late strobe after the end is free
    always_ff @(posedge i_clk_link or negedge i_rstn) begin
        if (!i_rstn) begin
            gap_q <= 2'h0;
            o_byte_done <= 1'b0;
            o_count <= 32'h0;
        end else begin
            gap_q <= gap_q + 2'h1;
            o_byte_done <= i_active && (!i_slow || gap_q == 2'h0);
            if (o_byte_done && i_active) begin
                o_count <= o_count + 32'h1;
            end
        end
    end
endmodule : qsflc_flash_model

// file: qsflc_bench.sv
// self-checking bench of the transfer-length block
// assumes the block's register map and the far-side model file
`timescale 1ns/1ps
`include "qsflc_params.svh"
module qsflc_bench;
    logic clk, clk_link, rstn, slow, awvalid, wvalid, bready;
    logic arvalid, rready, awready, wready, bvalid, arready, rvalid;
    logic busy, active, last, byte_done;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, nbytes, base, d, len, ctrl;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, r, fm;
    int n_fail, compares, cyc, n_last, lb;
    qsflc_top dut_u (.i_clk_sys(clk), .i_rstn(rstn), .i_clk_link(clk_link),
        .i_link_byte_done(byte_done), .i_awaddr(awaddr),
        .i_awvalid(awvalid), .o_awready(awready), .i_wdata(wdata),
        .i_wstrb(wstrb), .i_wvalid(wvalid), .o_wready(wready),
        .o_bresp(bresp), .o_bvalid(bvalid), .i_bready(bready),
        .i_araddr(araddr), .i_arvalid(arvalid), .o_arready(arready),
        .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid),
        .i_rready(rready), .o_busy(busy), .o_link_active(active),
        .o_link_last(last));
    qsflc_flash_model flash_u (.i_clk_link(clk_link), .i_rstn(rstn),
        .i_active(active), .i_slow(slow), .o_byte_done(byte_done),
        .o_count(nbytes));
    // clocks of unrelated phase
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    initial begin
        clk_link = 1'b0;
        #3.7;
        forever #6 clk_link = ~clk_link;
    end
    // count bytes taken while the block flagged them as the last one
    always @(negedge clk_link) begin
        if (active && byte_done && last) n_last++;
    end
    // cut a hang short
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            end_of_test();
        end
    end
    task automatic end_of_test();
        $display("compares %0d, mismatches %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : end_of_test
    task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("Error at %0t: value %h, expected %h", $time, got, exp);
        end
    endtask : chk32
    task automatic chk1(input logic got, input logic exp);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("Error at %0t: flag %b, expected %b", $time, got, exp);
        end
    endtask : chk1
    // one write, address and data offered together
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        r = bresp;
        bready <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clk);
            if (arvalid && arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask : rd
    task automatic wait_idle();
        do @(posedge clk); while (busy !== 1'b0);
    endtask : wait_idle
    // start a run and return the bytes the far side moved
    task automatic run(input logic [31:0] c);
        base = nbytes;
        lb = n_last;
        wr(`QSFLC_OFS_CTRL, c | 32'h1);
        wait_idle();
        d = nbytes - base;
        chk32(32'(n_last - lb), 32'h1);
    endtask : run
    function automatic logic [31:0] mk(input logic du, input logic [1:0] f,
        input logic [4:0] sz, input logic [1:0] op);
        return {19'h0, sz, 2'h0, f, 1'h0, du, op};
    endfunction : mk
    function automatic logic [31:0] exp_bytes(input logic [31:0] n,
        input logic du, input logic [31:0] adr, input logic [4:0] sz);
        if (n === `QSFLC_LEN_UNDEF) return (32'h1 << (sz + 5'h1)) - adr;
        return (du ? (n | 32'h1) : n) + 32'h1;
    endfunction : exp_bytes
    // main sequence
    initial begin
        {rstn, slow, awvalid, wvalid, bready, arvalid, rready} = 7'h0;
        awaddr = 8'h0;
        araddr = 8'h0;
        wdata = 32'h0;
        wstrb = 4'hf;
        void'($urandom(3));
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        repeat (2) @(posedge clk);
        rd(`QSFLC_OFS_LEN);
        chk32(d, `QSFLC_LEN_RST);
        rd(8'h10);
        chk32({30'h0, r}, {30'h0, `QSFLC_RESP_SLVERR});
        wr(8'h14, 32'h5);
        chk32({30'h0, r}, {30'h0, `QSFLC_RESP_SLVERR});
        $display("test register map done");
        // finite runs: corners first, then random counts, modes set by the loop index
        for (int i = 0; i < 8; i++) begin
            fm = (i % 3 == 2) ? `QSFLC_MODE_POLL : 2'(i % 2);
            len = (i < 2) ? 32'(i * 3) : 32'($urandom_range(0, 3));
            slow <= 1'($urandom_range(0, 1));
            ctrl = mk(i > 3, fm, `QSFLC_SIZE_MAX, 2'h0);
            wr(`QSFLC_OFS_CTRL, ctrl);
            wr(`QSFLC_OFS_LEN, len);
            rd(`QSFLC_OFS_LEN);
            chk32(d, (i > 3) ? (len | 32'h1) : len);
            run(ctrl);
            chk32(d, exp_bytes(len, i > 3, 32'h0, 5'h0));
        end
        $display("test finite counts done");
        wr(`QSFLC_OFS_ADDR, 32'h3);
        ctrl = mk(1'b0, 2'h1, 5'h2, 2'h0);
        wr(`QSFLC_OFS_CTRL, ctrl);
        wr(`QSFLC_OFS_LEN, `QSFLC_LEN_UNDEF);
        run(ctrl);
        chk32(d, exp_bytes(`QSFLC_LEN_UNDEF, 1'b0, 32'h3, 5'h2));
        $display("test undefined length done");
        // endless runs, a locked write in mid-run, then abort
        wr(`QSFLC_OFS_ADDR, 32'h0);
        for (int j = 0; j < 2; j++) begin
            len = j ? 32'h0 : `QSFLC_LEN_UNDEF;
            ctrl = mk(1'b0, j ? `QSFLC_MODE_MMAP : 2'h1, 5'h1f, 2'h0);
            wr(`QSFLC_OFS_CTRL, ctrl);
            wr(`QSFLC_OFS_LEN, len);
            lb = n_last;
            wr(`QSFLC_OFS_CTRL, ctrl | 32'h1);
            repeat (100) @(posedge clk);
            chk1(active, 1'b1);
            chk1(busy, 1'b1);
            wr(`QSFLC_OFS_LEN, 32'h5);
            chk32({30'h0, r}, {30'h0, `QSFLC_RESP_OKAY});
            rd(`QSFLC_OFS_LEN);
            chk32(d, len);
            wr(`QSFLC_OFS_CTRL, ctrl | 32'h2);
            wait_idle();
            chk1(active, 1'b0);
            chk32(32'(n_last - lb), 32'h0);
        end
        wr(`QSFLC_OFS_LEN, 32'h5);
        rd(`QSFLC_OFS_LEN);
        chk32(d, 32'h5);
        $display("test endless runs and lock done");
        end_of_test();
    end
endmodule : qsflc_bench
